// ### verilog/fsr_pkg.sv
// shared constants for the flash status register controller
package fsr_pkg;
    // ----------------------------------------------------------------
    // clock and self-timed write
    // ----------------------------------------------------------------
    localparam int CLK_MHZ = 25;                    // core clock rate
    localparam int T_STATUS_WRITE_US = 5000;        // self-timed status write, longest time
    localparam int STATUS_WRITE_CYCLES = T_STATUS_WRITE_US * CLK_MHZ; // exact product, 125000 cycles, above one
    localparam int TIMER_W = 24;                    // width of the write timer

    // ----------------------------------------------------------------
    // opcodes
    // ----------------------------------------------------------------
    localparam logic [7:0] OP_WRITE_STATUS_ONE = 8'h01;
    localparam logic [7:0] OP_WRITE_STATUS_TWO = 8'h31;
    localparam logic [7:0] OP_READ_STATUS_ONE = 8'h05;
    localparam logic [7:0] OP_READ_STATUS_TWO = 8'h35;
    localparam logic [7:0] OP_VOLATILE_ENABLE = 8'h50;
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OP_SUSPEND = 8'h75;
    localparam logic [7:0] OP_RESUME = 8'h7A;
    localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
    localparam logic [7:0] OP_QUAD_PAGE_PROGRAM = 8'h32;
    localparam logic [7:0] OP_ERASE_4K = 8'h20;
    localparam logic [7:0] OP_ERASE_32K = 8'h52;
    localparam logic [7:0] OP_ERASE_64K = 8'hD8;
    localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
    localparam logic [7:0] OP_CHIP_ERASE_B = 8'hC7;
    localparam logic [7:0] OP_SECURE_PROGRAM = 8'h42;

    // ----------------------------------------------------------------
    // frame bit counts
    // ----------------------------------------------------------------
    localparam logic [4:0] BITS_OPCODE = 5'h08;     // opcode complete
    localparam logic [4:0] BITS_WRITE = 5'h10;      // opcode plus one data byte
    localparam logic [4:0] BITS_MAX = 5'h11;        // saturation: too long

    // ----------------------------------------------------------------
    // status byte one fields
    // ----------------------------------------------------------------
    localparam int S1_PROTECT_LO = 7;
    localparam int S1_BLOCK_LSB = 2;                // block protect bits 6..2
    localparam int S1_WEL = 1;
    localparam int S1_BUSY = 0;
    localparam logic [7:0] WR_MASK_ONE = 8'hFC;     // writable bits of byte one

    // ----------------------------------------------------------------
    // status byte two fields
    // ----------------------------------------------------------------
    localparam int S2_ERASE_SUSP = 7;
    localparam int S2_COMPLEMENT = 6;
    localparam int S2_LOCK_LSB = 3;                 // locks one..three at bits 3..5
    localparam int S2_PROG_SUSP = 2;
    localparam int S2_QUAD = 1;
    localparam int S2_PROTECT_HI = 0;
    localparam logic [7:0] WR_MASK_TWO = 8'h7B;     // writable bits of byte two

    // ----------------------------------------------------------------
    // reset values (factory state: everything clear)
    // ----------------------------------------------------------------
    localparam logic [7:0] RESET_BYTE_ONE = 8'h00;
    localparam logic [7:0] RESET_BYTE_TWO = 8'h00;

    // ----------------------------------------------------------------
    // write engine states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        FSR_IDLE = 2'b00,
        FSR_TIMED = 2'b01
    } fsr_wstate_t;
endpackage : fsr_pkg

// ### verilog/fsr_status_ctrl.sv
// status register bank and write-status engine of a serial flash
`timescale 1ns/1ns
`default_nettype none

module fsr_status_ctrl
    import fsr_pkg::*;
#(
    parameter int STATUS_WRITE_TIME = STATUS_WRITE_CYCLES // shorten in simulation
) (
    input wire logic i_clk,                 // core clock
    input wire logic i_nrst,                // reset, active low: synchronous in the core domain, asynchronous in the link domain
    input wire logic i_sck,                 // serial clock from host
    input wire logic i_cs_n,                // chip select, active low
    input wire logic i_si,                  // serial data in
    input wire logic i_wp_n,                // write-protect pin, active low
    input wire logic i_array_busy,          // array engine running
    input wire logic i_array_is_erase,      // running operation is an erase
    input wire logic i_array_done,          // pulse: array op completed or aborted
    output logic o_so,                      // serial data out
    output logic o_so_oe_n,                 // low while o_so is driven
    output logic o_ready_busy,              // one while any operation runs
    output logic [4:0] o_block_protect,     // size, top/bottom, amount
    output logic o_protect_complement,      // invert protected region
    output logic [2:0] o_secure_lock,       // page locks three..one
    output logic o_quad_io_enable,          // hold and wp act as data lines
    output logic o_array_start,             // pulse: start guarded array op
    output logic [7:0] o_array_opcode,      // opcode of that op
    output logic o_suspend,                 // pulse: suspend array op
    output logic o_resume                   // pulse: resume array op
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // guarded array commands need the write latch
    function automatic logic is_guarded_array(input logic [7:0] op);
        is_guarded_array = (op == OP_PAGE_PROGRAM) || (op == OP_QUAD_PAGE_PROGRAM) ||
                           (op == OP_ERASE_4K) || (op == OP_ERASE_32K) || (op == OP_ERASE_64K) ||
                           (op == OP_CHIP_ERASE_A) || (op == OP_CHIP_ERASE_B) ||
                           (op == OP_SECURE_PROGRAM);
    endfunction : is_guarded_array

    function automatic logic is_status_write(input logic [7:0] op);
        is_status_write = (op == OP_WRITE_STATUS_ONE) || (op == OP_WRITE_STATUS_TWO);
    endfunction : is_status_write

    // ----------------------------------------------------------------
    // serial clock domain: frame capture
    // ----------------------------------------------------------------
    logic first;            // no edge seen yet in this frame
    logic [2:0] bit_phase;  // rises modulo eight, for read-out
    logic req_s1;
    logic req_s2;
    logic ack;
    logic [4:0] nbits;      // saturating rise count of the last frame
    logic [7:0] shreg;
    logic [7:0] frame_op;
    logic [7:0] frame_data;
    logic frame_tog;        // flips once per frame with edges
    logic [15:0] snap_sck;  // status bytes as seen by the link
    logic [4:0] cnt_now;
    logic rd_mode;
    logic [7:0] rd_byte;
    logic req;              // core offers a fresh snapshot
    logic [15:0] snap_core; // status bytes held still while req is high

    assign cnt_now = first ? 5'h00 : nbits;

    // per-frame state, cleared while select is high
    always_ff @(posedge i_sck or posedge i_cs_n) begin
        if (i_cs_n) begin
            first <= 1'b1;
            bit_phase <= 3'h0;
            req_s1 <= 1'b0;
            req_s2 <= 1'b0;
            ack <= 1'b0;
        end else begin
            first <= 1'b0;
            bit_phase <= bit_phase + 3'h1;
            req_s1 <= req;
            req_s2 <= req_s1;
            ack <= req_s2;
        end
    end

    // frame results must survive select going high: the core reads them then
    always_ff @(posedge i_sck or negedge i_nrst) begin
        if (!i_nrst) begin
            nbits <= 5'h00;
            shreg <= 8'h00;
            frame_op <= 8'h00;
            frame_data <= 8'h00;
            frame_tog <= 1'b0;
            snap_sck <= {RESET_BYTE_ONE, RESET_BYTE_TWO};
        end else begin
            shreg <= {shreg[6:0], i_si};
            if (first) begin
                frame_tog <= ~frame_tog;
            end
            nbits <= (cnt_now == BITS_MAX) ? BITS_MAX : cnt_now + 5'h01;
            if (cnt_now == BITS_OPCODE - 5'h01) begin
                frame_op <= {shreg[6:0], i_si};
            end
            if (cnt_now == BITS_WRITE - 5'h01) begin
                frame_data <= {shreg[6:0], i_si};
            end
            // capture only while the core holds the snapshot still
            if (req_s2 && !ack) begin
                snap_sck <= snap_core;
            end
        end
    end

    // ----------------------------------------------------------------
    // serial clock domain: status read-out on the falling edge
    // ----------------------------------------------------------------
    assign rd_mode = (nbits >= BITS_OPCODE) &&
                     ((frame_op == OP_READ_STATUS_ONE) || (frame_op == OP_READ_STATUS_TWO));
    assign rd_byte = (frame_op == OP_READ_STATUS_ONE) ? snap_sck[15:8] : snap_sck[7:0];

    // byte repeats every eight clocks; each pass uses the latest snapshot
    always_ff @(negedge i_sck or posedge i_cs_n) begin
        if (i_cs_n) begin
            o_so <= 1'b0;
            o_so_oe_n <= 1'b1;
        end else if (rd_mode) begin
            o_so <= rd_byte[3'h7 - bit_phase];
            o_so_oe_n <= 1'b0;
        end else begin
            o_so <= 1'b0;
            o_so_oe_n <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // core domain: pin synchronisers
    // ----------------------------------------------------------------
    logic cs_s1;
    logic cs_s2;
    logic cs_s3;
    logic wp_s1;
    logic wp_s2;
    logic ack_s1;
    logic ack_s2;

    // first stages feed only the second stages
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            cs_s1 <= 1'b1;
            cs_s2 <= 1'b1;
            cs_s3 <= 1'b1;
            wp_s1 <= 1'b1;
            wp_s2 <= 1'b1;
            ack_s1 <= 1'b0;
            ack_s2 <= 1'b0;
        end else begin
            cs_s1 <= i_cs_n;
            cs_s2 <= cs_s1;
            cs_s3 <= cs_s2;
            wp_s1 <= i_wp_n;
            wp_s2 <= wp_s1;
            ack_s1 <= ack;
            ack_s2 <= ack_s1;
        end
    end

    // ----------------------------------------------------------------
    // core domain: frame end detection
    // ----------------------------------------------------------------
    logic seen_tog;
    logic frame_end;
    logic [7:0] fop;
    logic fop_full;

    // frame registers are still once select is high and the clock has stopped
    assign frame_end = cs_s2 && !cs_s3 && (frame_tog != seen_tog);
    assign fop = frame_op;
    assign fop_full = (nbits >= BITS_OPCODE);

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            seen_tog <= 1'b0;
        end else if (cs_s2 && !cs_s3) begin
            seen_tog <= frame_tog;
        end
    end

    // ----------------------------------------------------------------
    // core domain: status bits
    // ----------------------------------------------------------------
    logic [7:0] nv_one;     // non-volatile writable bits, byte one
    logic [7:0] nv_two;
    logic [7:0] vol_one;    // working copy, byte one
    logic [7:0] vol_two;
    logic write_enable_latch;
    logic erase_suspended_flag;
    logic program_suspended_flag;
    logic vol_armed;
    fsr_wstate_t wstate;
    logic [TIMER_W-1:0] wtimer;
    logic [7:0] wpend;
    logic wpend_two;
    logic write_progress_flag;
    logic ready_busy_flag;
    logic status_protect_lo;
    logic status_protect_hi;
    logic hw_locked;
    logic write_allowed;
    logic [7:0] status_one;
    logic [7:0] status_two;
    logic is_wr;
    logic wr_exact;

    assign write_progress_flag = (wstate == FSR_TIMED);
    assign ready_busy_flag = write_progress_flag | i_array_busy;
    assign status_protect_lo = vol_one[S1_PROTECT_LO];
    assign status_protect_hi = vol_two[S2_PROTECT_HI];

    // in quad mode the pin carries data, so it can no longer protect
    assign hw_locked = (status_protect_hi && !status_protect_lo) ||
                       (!status_protect_hi && status_protect_lo && !wp_s2 &&
                        !vol_two[S2_QUAD]);
    assign write_allowed = !hw_locked && !ready_busy_flag;

    assign status_one = {vol_one[7:2], write_enable_latch, ready_busy_flag};
    assign status_two = {erase_suspended_flag, vol_two[6:3], program_suspended_flag,
                         vol_two[1:0]};

    assign is_wr = is_status_write(fop) && fop_full;
    assign wr_exact = (nbits == BITS_WRITE);

    // write engine: volatile writes land at once, latched writes are timed
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            wstate <= FSR_IDLE;
            wtimer <= '0;
            wpend <= 8'h00;
            wpend_two <= 1'b0;
        end else begin
            case (wstate)
                FSR_IDLE: begin
                    if (frame_end && is_wr && wr_exact && write_allowed && !vol_armed && write_enable_latch) begin
                        wstate <= FSR_TIMED;
                        wtimer <= TIMER_W'(STATUS_WRITE_TIME - 1);
                        wpend <= frame_data;
                        wpend_two <= (fop == OP_WRITE_STATUS_TWO);
                    end
                end
                FSR_TIMED: begin
                    if (wtimer == '0) begin
                        wstate <= FSR_IDLE;
                    end else begin
                        wtimer <= wtimer - TIMER_W'(1);
                    end
                end
                default: begin
                    wstate <= FSR_IDLE;
                end
            endcase
        end
    end

    // writable bits; reset models power-up, loading the working copy
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            nv_one <= RESET_BYTE_ONE;
            nv_two <= RESET_BYTE_TWO;
            vol_one <= RESET_BYTE_ONE;
            vol_two <= RESET_BYTE_TWO;
        end else if (wstate == FSR_TIMED && wtimer == '0) begin
            if (wpend_two) begin
                nv_two <= (nv_two & ~WR_MASK_TWO) | (wpend & WR_MASK_TWO);
                vol_two <= (vol_two & ~WR_MASK_TWO) | (wpend & WR_MASK_TWO);
            end else begin
                nv_one <= (nv_one & ~WR_MASK_ONE) | (wpend & WR_MASK_ONE);
                vol_one <= (vol_one & ~WR_MASK_ONE) | (wpend & WR_MASK_ONE);
            end
        end else if (frame_end && is_wr && wr_exact && write_allowed && vol_armed) begin
            // volatile update leaves the stored copy untouched
            if (fop == OP_WRITE_STATUS_TWO) begin
                vol_two <= (vol_two & ~WR_MASK_TWO) | (frame_data & WR_MASK_TWO);
            end else begin
                vol_one <= (vol_one & ~WR_MASK_ONE) | (frame_data & WR_MASK_ONE);
            end
        end
    end

    // volatile enable is good for the very next status write only
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            vol_armed <= 1'b0;
        end else if (frame_end && fop_full && fop == OP_VOLATILE_ENABLE && !ready_busy_flag) begin
            vol_armed <= 1'b1;
        end else if (frame_end && is_wr) begin
            vol_armed <= 1'b0;
        end
    end

    // write latch; a set in the same cycle as a clear wins
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            write_enable_latch <= 1'b0;
        end else if (frame_end && fop_full && fop == OP_WRITE_ENABLE && !ready_busy_flag) begin
            write_enable_latch <= 1'b1;
        end else if (frame_end && fop_full && fop == OP_WRITE_DISABLE && !ready_busy_flag) begin
            write_enable_latch <= 1'b0;
        end else if (wstate == FSR_TIMED && wtimer == '0) begin
            write_enable_latch <= 1'b0;
        end else if (frame_end && is_wr && !vol_armed && !(wr_exact && write_allowed)) begin
            write_enable_latch <= 1'b0;
        end else if (i_array_done) begin
            write_enable_latch <= 1'b0;
        end
    end

    // suspend flags follow the array engine, set wins over clear
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            erase_suspended_flag <= 1'b0;
            program_suspended_flag <= 1'b0;
        end else if (frame_end && fop_full && fop == OP_SUSPEND && i_array_busy) begin
            erase_suspended_flag <= erase_suspended_flag | i_array_is_erase;
            program_suspended_flag <= program_suspended_flag | !i_array_is_erase;
        end else if (frame_end && fop_full && fop == OP_RESUME) begin
            erase_suspended_flag <= 1'b0;
            program_suspended_flag <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // core domain: commands to the array engine
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            o_array_start <= 1'b0;
            o_array_opcode <= 8'h00;
            o_suspend <= 1'b0;
            o_resume <= 1'b0;
        end else begin
            o_array_start <= frame_end && fop_full && is_guarded_array(fop) &&
                             write_enable_latch && !ready_busy_flag;
            if (frame_end && fop_full) begin
                o_array_opcode <= fop;
            end
            o_suspend <= frame_end && fop_full && fop == OP_SUSPEND && i_array_busy;
            o_resume <= frame_end && fop_full && fop == OP_RESUME &&
                        (erase_suspended_flag || program_suspended_flag);
        end
    end

    // ----------------------------------------------------------------
    // core domain: snapshot handshake toward the link
    // ----------------------------------------------------------------
    // four-phase: the snapshot only changes while the link is not sampling it
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            req <= 1'b0;
            snap_core <= {RESET_BYTE_ONE, RESET_BYTE_TWO};
        end else if (!req && !ack_s2) begin
            req <= 1'b1;
            snap_core <= {status_one, status_two};
        end else if (req && ack_s2) begin
            req <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // core domain: registered outputs
    // ----------------------------------------------------------------
    // protection fields go to the array map, which decodes regions and locks
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            o_ready_busy <= 1'b0;
            o_block_protect <= 5'h00;
            o_protect_complement <= 1'b0;
            o_secure_lock <= 3'h0;
            o_quad_io_enable <= 1'b0;
        end else begin
            o_ready_busy <= ready_busy_flag;
            o_block_protect <= vol_one[S1_BLOCK_LSB +: 5];
            o_protect_complement <= vol_two[S2_COMPLEMENT];
            o_secure_lock <= vol_two[S2_LOCK_LSB +: 3];
            o_quad_io_enable <= vol_two[S2_QUAD];
        end
    end

endmodule : fsr_status_ctrl

`default_nettype wire

// ### sim/fsr_status_ctrl_sva.sv
// assertions on the status controller ports
`timescale 1ns/1ns
`default_nettype none
module fsr_status_ctrl_sva (
    input wire logic i_clk, // clock
    input wire logic i_nrst, // reset
    input wire logic i_cs_n, // select
    input wire logic i_array_busy, // array running
    input wire logic o_so_oe_n, // so enable
    input wire logic o_ready_busy, // busy
    input wire logic [4:0] o_block_protect, // protect field
    input wire logic o_array_start, // start pulse
    input wire logic [7:0] o_array_opcode, // started op
    input wire logic o_suspend, // suspend pulse
    input wire logic o_resume // resume pulse
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    // three edges deselected: the async release has surely landed
    sequence s_idle;
        i_cs_n [*3];
    endsequence
    a_so_released: assert property (s_idle |-> o_so_oe_n) else $error("so driven");
    a_reset_clear: assert property ($rose(i_nrst) |-> o_block_protect == 5'h00 && !o_ready_busy) else $error("dirty");
    a_busy_track: assert property (i_array_busy |=> o_ready_busy) else $error("busy lost");
    a_start_pulse: assert property (o_array_start |=> !o_array_start) else $error("long start");
    a_start_guarded: assert property (o_array_start |-> o_array_opcode inside
        {8'h02, 8'h32, 8'h20, 8'h52, 8'hD8, 8'h60, 8'hC7, 8'h42}) else $error("bad start");
    a_susp_pulse: assert property (o_suspend |-> $past(i_array_busy) ##1 !o_suspend) else $error("bad susp");
    a_resume_pulse: assert property (o_resume |=> !o_resume) else $error("long resume");
    a_pulse_apart: assert property (o_suspend |-> !o_resume) else $error("both pulses");
endmodule : fsr_status_ctrl_sva
bind fsr_status_ctrl fsr_status_ctrl_sva i_fsr_status_ctrl_sva (.i_clk, .i_nrst, .i_cs_n, .i_array_busy,
    .o_so_oe_n, .o_ready_busy, .o_block_protect, .o_array_start, .o_array_opcode, .o_suspend, .o_resume);
`default_nettype wire

// ### sim/fsr_host_model.sv
// host side: one spi mode 0 frame at a time
`timescale 1ns/1ns
`default_nettype none
module fsr_host_model (
    output logic o_sck, // link clock, still between frames
    output logic o_cs_n, // chip select
    output logic o_si, // data to device
    input wire logic i_so, // data from device
    input wire logic i_so_oe_n // low while device drives
);
    // select rises at 1 ns so the link side sees a clean release edge
    initial begin
        {o_sck, o_cs_n, o_si} = 3'b000;
        #1 o_cs_n = 1'b1;
    end
    // msb first, last byte kept; si flips after a frame so no stale level lingers
    task automatic xfer(input logic [31:0] d, input int n, output logic [7:0] rd);
        rd = 8'h00;
        o_cs_n = 1'b0;
        for (int i = 31; i > 31 - n; i--) begin
            o_si = d[i];
            #7 o_sck = 1'b1;
            rd = {rd[6:0], i_so_oe_n ? ~rd[0] : i_so};
            #8 o_sck = 1'b0;
        end
        #8 o_cs_n = 1'b1;
        o_si = ~o_si;
        #400;
    endtask : xfer
endmodule : fsr_host_model
`default_nettype wire

// ### sim/fsr_status_ctrl_tb_top.sv
// bench: host frames against the status controller
`timescale 1ns/1ns
`default_nettype none
module fsr_status_ctrl_tb_top import fsr_pkg::*;;
    logic i_clk, i_nrst, i_sck, i_cs_n, i_si, i_wp_n, i_array_busy, i_array_is_erase, i_array_done;
    logic o_so, o_so_oe_n, o_ready_busy, o_protect_complement, o_quad_io_enable, o_array_start, o_suspend, o_resume;
    logic [4:0] o_block_protect;
    logic [2:0] o_secure_lock;
    logic [7:0] o_array_opcode, rd;
    int n_errors = 0, checked = 0, cycles = 0;
    int n_start = 0, n_susp = 0, n_res = 0;
    fsr_status_ctrl #(.STATUS_WRITE_TIME(20)) i_fsr_status_ctrl (.i_clk, .i_nrst, .i_sck, .i_cs_n, .i_si,
        .i_wp_n, .i_array_busy, .i_array_is_erase, .i_array_done, .o_so, .o_so_oe_n, .o_ready_busy,
        .o_block_protect, .o_protect_complement, .o_secure_lock, .o_quad_io_enable, .o_array_start,
        .o_array_opcode, .o_suspend, .o_resume);
    fsr_host_model i_fsr_host_model (.o_sck(i_sck), .o_cs_n(i_cs_n), .o_si(i_si), .i_so(o_so), .i_so_oe_n(o_so_oe_n));
    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end
    // pulse counters, taken mid-cycle where the registered outputs have settled
    always @(negedge i_clk) begin
        n_start += (o_array_start === 1'b1);
        n_susp += (o_suspend === 1'b1);
        n_res += (o_resume === 1'b1);
    end
    // the sequence needs about 1000 cycles
    always @(posedge i_clk) if (++cycles == 9000) begin
        n_errors++;
        wrap_up();
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t seen %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic send(input logic [7:0] op, input logic [7:0] dat, input int n);
        i_fsr_host_model.xfer({op, dat, 16'h0000}, n, rd);
        @(posedge i_clk);
        #1;
    endtask : send
    // the first byte may hold a snapshot from the last frame's end; the third is refreshed in-frame
    task automatic rdchk(input logic [7:0] op, input logic [7:0] exp);
        send(op, 8'h00, 32);
        chk(rd, exp);
    endtask : rdchk
    // keep reading byte one until busy drops, bounded by eight polls
    task automatic poll;
        int n = 0;
        do begin
            send(OP_READ_STATUS_ONE, 8'h00, 32);
            n++;
        end while (rd[0] !== 1'b0 && n < 8);
        chk({7'h00, rd[0]}, 8'h00);
    endtask : poll
    // latch, write, then poll until the timed write is over
    task automatic wr(input logic [7:0] op, input logic [7:0] dat);
        send(OP_WRITE_ENABLE, 8'h00, 8);
        send(op, dat, 16);
        poll();
    endtask : wr
    task automatic wrap_up;
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : wrap_up
    initial begin
        {i_nrst, i_wp_n, i_array_busy, i_array_is_erase, i_array_done} = 5'b11000;
        #1 i_nrst = 1'b0;
        repeat (16) @(posedge i_clk);
        #1 i_nrst = 1'b1;
        repeat (4) @(posedge i_clk);
        #1;
        rdchk(8'h35, 8'h00);
        send(8'h01, 8'hFC, 16);
        rdchk(8'h05, 8'h00);
        send(OP_WRITE_ENABLE, 8'h00, 8);
        rdchk(8'h05, 8'h02);
        send(8'h01, 8'hFF, 16);
        chk({7'h00, o_ready_busy}, 8'h01);
        poll();
        rdchk(8'h05, 8'hFC);
        i_wp_n = 1'b0;
        wr(8'h01, 8'h00);
        rdchk(8'h05, 8'hFC);
        i_wp_n = 1'b1;
        wr(8'h01, 8'h1C);
        rdchk(8'h05, 8'h1C);
        chk({3'h0, o_block_protect}, 8'h07);
        send(OP_WRITE_ENABLE, 8'h00, 8);
        send(8'h01, 8'h00, 15);
        rdchk(8'h05, 8'h1C);
        send(OP_WRITE_ENABLE, 8'h00, 8);
        send(8'h01, 8'h00, 4);
        rdchk(8'h05, 8'h1E);
        send(8'h02, 8'h00, 8);
        chk(o_array_opcode, 8'h02);
        chk(8'(n_start), 8'h01);
        i_array_done = 1'b1;
        @(posedge i_clk);
        #1 i_array_done = 1'b0;
        rdchk(8'h05, 8'h1C);
        send(8'h20, 8'h00, 8);
        chk(8'(n_start), 8'h01);
        send(8'h50, 8'h00, 8);
        send(8'h01, 8'h5C, 16);
        rdchk(8'h05, 8'h5C);
        {i_array_busy, i_array_is_erase} = 2'b11;
        send(8'h75, 8'h00, 8);
        rdchk(8'h35, 8'h80);
        send(8'h7A, 8'h00, 8);
        rdchk(8'h35, 8'h00);
        i_array_is_erase = 1'b0;
        send(8'h75, 8'h00, 8);
        rdchk(8'h35, 8'h04);
        send(8'h7A, 8'h00, 8);
        chk({7'h00, o_ready_busy}, 8'h01);
        chk(8'(n_susp), 8'h02);
        chk(8'(n_res), 8'h02);
        i_array_busy = 1'b0;
        wr(8'h31, 8'hFF);
        rdchk(8'h35, 8'h7B);
        chk({3'h0, o_quad_io_enable, o_protect_complement, o_secure_lock}, 8'h1F);
        wr(8'h31, 8'h00);
        rdchk(8'h35, 8'h7B);
        // power cycle: protect bits and latch come back clear
        i_nrst = 1'b0;
        repeat (16) @(posedge i_clk);
        #1 i_nrst = 1'b1;
        repeat (4) @(posedge i_clk);
        #1;
        rdchk(8'h35, 8'h00);
        rdchk(8'h05, 8'h00);
        wrap_up();
    end
endmodule : fsr_status_ctrl_tb_top
`default_nettype wire
